/* File: pkg/spc_defines.vh */
// Offsets, field positions, reset values and timing counts of the sleep/idle power controller
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define SPC_OFF_CPUCTL 12'h000
`define SPC_OFF_VREG 12'h004
`define SPC_OFF_OSCFORCE 12'h008
`define SPC_OFF_STATUS 12'h00c
`define SPC_OFF_CMD 12'h010
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SPC_CPU_IDLE 7
`define SPC_CPU_REDUCED_RATE_ENABLE 6
`define SPC_CPU_ROI 5
`define SPC_VREG_LP 1
`define SPC_VREG_RSVD 0
`define SPC_OSC_HF 0
`define SPC_OSC_LF 1
`define SPC_OSC_SEC 2
`define SPC_CMD_SLEEP 0
`define SPC_CMD_PDCLR 1
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SPC_RST_CPUCTL 8'h00
`define SPC_RST_VREG 2'h1
`define SPC_RST_OSCFORCE 3'h0
// ------------------------------------------------------------
// Timing and interrupt vector
// ------------------------------------------------------------
`define SPC_OST_PERIODS 1024
`define SPC_VREG_SETTLE_NS 2000
`define SPC_CLK_NS 40
`define SPC_VREG_CYCLES ((`SPC_VREG_SETTLE_NS + `SPC_CLK_NS - 1) / `SPC_CLK_NS)
`define SPC_IRQ_VECTOR 16'h0004
`endif

/* File: hdl/spc_power_ctrl.v */
// Sleep and Idle power-state controller with APB register access
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/100ps
`include "spc_defines.vh"
module spc_power_ctrl #(
  parameter REGULATED = 1,
  parameter VREG_CYCLES = `SPC_VREG_CYCLES,
  parameter OST_PERIODS = `SPC_OST_PERIODS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sleep_exec,
  input wire irq_wake_group0,
  input wire irq_wake_periph,
  input wire irq_clock_switch,
  input wire peripheral_irq_enable,
  input wire global_irq_enable,
  input wire isr_entry,
  input wire reset_source_pin,
  input wire wdt_enabled_in_sleep,
  input wire wdt_timeout_pin,
  input wire program_flash_ready_pin,
  input wire osc_ready_pin,
  input wire brownout_ready_pin,
  input wire brownout_enable,
  input wire crystal_mode,
  input wire osc_clk_pin,
  input wire low_freq_osc_req,
  input wire high_freq_osc_req,
  input wire second_osc_req,
  input wire adc_on_bit,
  input wire adc_on_rc_clock,
  input wire clock_out_enable_n,
  input wire [7:0] port_periph_active,
  output reg cpu_clk_en_ff,
  output reg sys_clk_en_ff,
  output reg periph_clk_en_ff,
  output reg clk_out_en_ff,
  output reg low_freq_internal_osc_en_ff,
  output reg high_freq_internal_osc_en_ff,
  output reg secondary_osc_en_ff,
  output reg adc_abort_ff,
  output reg adc_power_en_ff,
  output reg [7:0] port_hold_ff,
  output reg regulator_low_power_ff,
  output reg watchdog_clear_ff,
  output reg device_reset_ff,
  output reg exec_prefetch_ff,
  output reg vector_req_ff,
  output reg [15:0] vector_addr_ff,
  output reg cpu_run_ff,
  output reg power_down_flag_ff,
  output reg timeout_flag_ff
);
  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam ST_RUN = 3'h0;
  localparam ST_SLEEP = 3'h1;
  localparam ST_IDLE = 3'h2;
  localparam ST_OST = 3'h3;
  localparam ST_VREG = 3'h4;
  localparam ST_READY = 3'h5;
  localparam ST_PREF = 3'h6;
  localparam ST_VEC = 3'h7;

  // ------------------------------------------------------------
  // Synchronisers for pins from outside the clock domain
  // ------------------------------------------------------------
  localparam NSYNC = 6;
  wire [NSYNC-1:0] raw_in;
  reg [NSYNC-1:0] sync1_ff;
  reg [NSYNC-1:0] sync2_ff;
  assign raw_in = {osc_clk_pin, reset_source_pin, wdt_timeout_pin,
                   program_flash_ready_pin, osc_ready_pin, brownout_ready_pin};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= {NSYNC{1'b0}};
      sync2_ff <= {NSYNC{1'b0}};
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end
  wire osc_s = sync2_ff[5];
  wire rst_src = sync2_ff[4];
  wire wdt_to = sync2_ff[3];
  wire flash_rdy = sync2_ff[2];
  wire osc_rdy = sync2_ff[1];
  wire bor_rdy = sync2_ff[0];

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg [7:0] cpuctl_ff;
  reg [1:0] vreg_ff;
  reg [2:0] oscforce_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [11:0] cnt_ff;
  reg [11:0] nxt_cnt;
  reg osc_d_ff;
  reg was_sleep_ff;
  reg irq_wake_ff;
  reg [7:0] port_snap_ff;

  wire idle_on_sleep_select = cpuctl_ff[`SPC_CPU_IDLE];
  wire recover_on_interrupt = cpuctl_ff[`SPC_CPU_ROI];
  wire regulator_sleep_power_select = vreg_ff[`SPC_VREG_LP];
  // A pending clock-switch interrupt blocks waking from every interrupt source; a watchdog timeout still ends Idle
  wire irq_pending = (irq_wake_group0 | (irq_wake_periph & peripheral_irq_enable)) & ~irq_clock_switch;
  wire sleep_req = sleep_exec & (state_ff == ST_RUN);
  wire osc_edge = osc_s & ~osc_d_ff;
  wire ready_all = flash_rdy & osc_rdy & (bor_rdy | ~brownout_enable);

  // APB decode: single-cycle access, zero wait states
  wire apb_acc = psel & penable;
  wire apb_wr = apb_acc & pwrite;
  wire hit_cpu = (paddr == `SPC_OFF_CPUCTL);
  wire hit_vreg = (paddr == `SPC_OFF_VREG);
  wire hit_osc = (paddr == `SPC_OFF_OSCFORCE);
  wire hit_stat = (paddr == `SPC_OFF_STATUS);
  wire hit_cmd = (paddr == `SPC_OFF_CMD);
  wire hit_any = hit_cpu | hit_vreg | hit_osc | hit_stat | hit_cmd;
  wire sw_sleep = apb_wr & hit_cmd & pwdata[`SPC_CMD_SLEEP];
  wire sw_pd_set = apb_wr & hit_cmd & pwdata[`SPC_CMD_PDCLR];
  wire do_sleep = sleep_req | (sw_sleep & (state_ff == ST_RUN));
  wire goes_nop = do_sleep & irq_pending;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ST_RUN: begin
        if (do_sleep & ~irq_pending) begin
          nxt_state = idle_on_sleep_select ? ST_IDLE : ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (irq_pending) begin
          nxt_state = crystal_mode ? ST_OST : ST_VREG;
          nxt_cnt = 12'h000;
        end
      end
      ST_IDLE: begin
        if (irq_pending | wdt_to) begin
          nxt_state = ST_READY;
        end
      end
      ST_OST: begin
        if (osc_edge) begin
          nxt_cnt = cnt_ff + 12'h001;
        end
        if (cnt_ff == OST_PERIODS[11:0]) begin
          nxt_state = ST_VREG;
          nxt_cnt = 12'h000;
        end
      end
      ST_VREG: begin
        // Only a regulated part in low-power mode pays the settle time
        if ((REGULATED == 0) || !regulator_sleep_power_select ||
            (cnt_ff == VREG_CYCLES[11:0])) begin
          nxt_state = ST_READY;
        end else begin
          nxt_cnt = cnt_ff + 12'h001;
        end
      end
      ST_READY: begin
        if (ready_all) begin
          nxt_state = irq_wake_ff ? ST_PREF : ST_RUN;
        end
      end
      ST_PREF: begin
        nxt_state = global_irq_enable ? ST_VEC : ST_RUN;
      end
      ST_VEC: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // ------------------------------------------------------------
  // State decode helpers
  // ------------------------------------------------------------
  // Shared so clock gating and wake detection cannot disagree on what halted means
  function is_halt;
    input [2:0] st;
    begin
      is_halt = (st == ST_SLEEP) | (st == ST_IDLE);
    end
  endfunction

  function is_exec;
    input [2:0] st;
    begin
      is_exec = (st == ST_RUN) | (st == ST_PREF) | (st == ST_VEC);
    end
  endfunction

  wire waking = is_halt(state_ff) & (nxt_state != state_ff);
  wire in_sleep = (state_ff == ST_SLEEP);
  wire in_idle = (state_ff == ST_IDLE);

  // ------------------------------------------------------------
  // Port hold
  // ------------------------------------------------------------
  // Each pin is judged alone: a peripheral becoming active frees only its own pin
  wire [7:0] hold_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_hold
      assign hold_nxt[gi] = in_sleep & port_snap_ff[gi] & ~port_periph_active[gi];
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_RUN;
      cnt_ff <= 12'h000;
      osc_d_ff <= 1'b0;
      was_sleep_ff <= 1'b0;
      irq_wake_ff <= 1'b0;
      port_snap_ff <= 8'h00;
      cpuctl_ff <= `SPC_RST_CPUCTL;
      vreg_ff <= `SPC_RST_VREG;
      oscforce_ff <= `SPC_RST_OSCFORCE;
      power_down_flag_ff <= 1'b1;
      timeout_flag_ff <= 1'b1;
      watchdog_clear_ff <= 1'b0;
      device_reset_ff <= 1'b0;
      exec_prefetch_ff <= 1'b0;
      vector_req_ff <= 1'b0;
      vector_addr_ff <= 16'h0000;
      cpu_run_ff <= 1'b1;
      cpu_clk_en_ff <= 1'b1;
      sys_clk_en_ff <= 1'b1;
      periph_clk_en_ff <= 1'b1;
      clk_out_en_ff <= 1'b0;
      low_freq_internal_osc_en_ff <= 1'b1;
      high_freq_internal_osc_en_ff <= 1'b1;
      secondary_osc_en_ff <= 1'b1;
      adc_abort_ff <= 1'b0;
      adc_power_en_ff <= 1'b0;
      port_hold_ff <= 8'h00;
      regulator_low_power_ff <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      osc_d_ff <= osc_s;
      if (do_sleep & ~irq_pending) begin
        was_sleep_ff <= ~idle_on_sleep_select;
        port_snap_ff <= ~port_periph_active;
      end
      if (waking) begin
        irq_wake_ff <= irq_pending;
      end

      // ------------------------------------------------------------
      // Status flags
      // ------------------------------------------------------------
      // Status flags: sleep entry, or software setting power_down via command
      if (do_sleep & ~goes_nop) begin
        power_down_flag_ff <= 1'b0;
        timeout_flag_ff <= 1'b1;
      end else if (sw_pd_set) begin
        power_down_flag_ff <= 1'b1;
      end

      // ------------------------------------------------------------
      // Watchdog, reset and core handshake
      // ------------------------------------------------------------
      // Watchdog clear pulses on entry and on every wake, never on a no-op sleep
      watchdog_clear_ff <= (do_sleep & ~goes_nop) | waking;
      // Full reset from reset sources, or a watchdog timeout outside Idle
      device_reset_ff <= rst_src | (wdt_to & ~in_idle);
      exec_prefetch_ff <= (state_ff == ST_PREF);
      vector_req_ff <= (state_ff == ST_VEC);
      vector_addr_ff <= `SPC_IRQ_VECTOR;
      cpu_run_ff <= is_exec(nxt_state);

      // ------------------------------------------------------------
      // Clock and oscillator enables
      // ------------------------------------------------------------
      // Clock enables are driven from the next state so gating lands on the entry edge itself; oscillator enables follow the current state
      cpu_clk_en_ff <= ~is_halt(nxt_state);
      sys_clk_en_ff <= ~(nxt_state == ST_SLEEP);
      periph_clk_en_ff <= ~(nxt_state == ST_SLEEP);
      clk_out_en_ff <= ~clock_out_enable_n & (nxt_state != ST_SLEEP);
      low_freq_internal_osc_en_ff <= ~in_sleep | low_freq_osc_req | oscforce_ff[`SPC_OSC_LF];
      high_freq_internal_osc_en_ff <= ~in_sleep | high_freq_osc_req | oscforce_ff[`SPC_OSC_HF];
      secondary_osc_en_ff <= ~in_sleep | second_osc_req | oscforce_ff[`SPC_OSC_SEC];

      // ------------------------------------------------------------
      // Analog, ports and regulator
      // ------------------------------------------------------------
      // No abort pulse for a converter that is switched off: nothing to abort
      adc_abort_ff <= do_sleep & ~goes_nop & ~idle_on_sleep_select & ~adc_on_rc_clock & adc_on_bit;
      adc_power_en_ff <= adc_on_bit & ~(in_sleep & ~adc_on_rc_clock);
      port_hold_ff <= hold_nxt;
      regulator_low_power_ff <= in_sleep & regulator_sleep_power_select & (REGULATED != 0);

      // ------------------------------------------------------------
      // Software registers
      // ------------------------------------------------------------
      if (apb_wr & hit_cpu) begin
        cpuctl_ff <= pwdata[7:0];
      end else if (isr_entry & recover_on_interrupt) begin
        cpuctl_ff[`SPC_CPU_REDUCED_RATE_ENABLE] <= 1'b0;
      end else if ((state_ff == ST_READY) & ready_all & irq_wake_ff & was_sleep_ff == 1'b0 &
                   recover_on_interrupt) begin
        cpuctl_ff[`SPC_CPU_REDUCED_RATE_ENABLE] <= 1'b0;
      end
      if (apb_wr & hit_vreg) begin
        vreg_ff <= {pwdata[`SPC_VREG_LP], 1'b1};
      end
      if (apb_wr & hit_osc) begin
        oscforce_ff <= pwdata[2:0];
      end

      // ------------------------------------------------------------
      // APB response
      // ------------------------------------------------------------
      // Ready is raised for the access cycle only; no wait states are ever inserted
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      if (psel & ~penable & ~pwrite) begin
        prdata <= hit_cpu ? {24'h000000, cpuctl_ff} :
                  hit_vreg ? {30'h00000000, vreg_ff} :
                  hit_osc ? {29'h00000000, oscforce_ff} :
                  hit_stat ? {24'h000000, state_ff, was_sleep_ff, irq_wake_ff, 1'b0,
                              timeout_flag_ff, power_down_flag_ff} :
                  32'h00000000;
      end
    end
  end
endmodule // spc_power_ctrl

/* File: tb/spc_monitor.sv */
// Concurrent checks on the sleep/idle power controller ports
`timescale 1ns/100ps
module spc_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire sleep_exec,
  input wire irq_wake_group0,
  input wire irq_wake_periph,
  input wire irq_clock_switch,
  input wire program_flash_ready_pin,
  input wire wdt_timeout_pin,
  input wire clock_out_enable_n,
  input wire cpu_clk_en_ff,
  input wire periph_clk_en_ff,
  input wire clk_out_en_ff,
  input wire watchdog_clear_ff,
  input wire device_reset_ff,
  input wire exec_prefetch_ff,
  input wire vector_req_ff,
  input wire [15:0] vector_addr_ff,
  input wire cpu_run_ff,
  input wire power_down_flag_ff,
  input wire timeout_flag_ff
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Sleep taken while running with nothing pending
  sequence s_entry;
    sleep_exec && cpu_run_ff && !irq_wake_group0 && !irq_wake_periph && !irq_clock_switch;
  endsequence
  sequence s_noop;
    sleep_exec && cpu_run_ff && irq_wake_group0 && !irq_clock_switch;
  endsequence
  sequence s_idle;
    !cpu_clk_en_ff && periph_clk_en_ff;
  endsequence
  chk_apb_zero_wait: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  chk_entry_flags: assert property (s_entry |=> !power_down_flag_ff && timeout_flag_ff)
    else $error("flags wrong after sleep entry");
  chk_entry_gate: assert property (s_entry |=> watchdog_clear_ff && !cpu_clk_en_ff)
    else $error("no watchdog clear or cpu clock gate");
  chk_noop_hold: assert property (s_noop |=> $stable(power_down_flag_ff) && $stable(timeout_flag_ff) && !watchdog_clear_ff)
    else $error("pending interrupt sleep changed state");
  chk_vector_after: assert property (vector_req_ff |-> vector_addr_ff == 16'h0004 && ($past(exec_prefetch_ff) || $past(exec_prefetch_ff, 2)))
    else $error("vector without prefetched instruction");
  chk_exec_ready: assert property ($rose(exec_prefetch_ff) |-> $past(program_flash_ready_pin, 2))
    else $error("execution before flash ready");
  chk_idle_wdt: assert property (s_idle ##0 wdt_timeout_pin |-> !device_reset_ff [*6])
    else $error("watchdog reset in idle");
  chk_clkout_idle: assert property (s_idle ##1 s_idle ##0 !clock_out_enable_n |-> clk_out_en_ff)
    else $error("clock output stopped in idle");
endmodule // spc_monitor

bind spc_power_ctrl spc_monitor u_mon (.pclk, .presetn, .psel, .penable, .pready, .sleep_exec, .irq_wake_group0,
  .irq_wake_periph, .irq_clock_switch, .program_flash_ready_pin, .wdt_timeout_pin, .clock_out_enable_n,
  .cpu_clk_en_ff, .periph_clk_en_ff, .clk_out_en_ff, .watchdog_clear_ff, .device_reset_ff, .exec_prefetch_ff,
  .vector_req_ff, .vector_addr_ff, .cpu_run_ff, .power_down_flag_ff, .timeout_flag_ff);

/* File: tb/spc_core_model.sv */
// Core-side oscillator and readiness model
`timescale 1ns/100ps
module spc_core_model (
  input wire pclk,
  input wire presetn,
  input wire slow,
  input wire cpu_clk_en_ff,
  output reg osc_clk_pin,
  output wire program_flash_ready_pin,
  output wire osc_ready_pin
);
  reg [5:0] wait_ff;
  reg was_on_ff;
  // Readiness drops on every low-power entry; slow mode outlasts a quick wake
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_clk_pin <= 1'b0;
      wait_ff <= 6'h00;
      was_on_ff <= 1'b1;
    end else begin
      osc_clk_pin <= ~osc_clk_pin;
      was_on_ff <= cpu_clk_en_ff;
      if (was_on_ff && !cpu_clk_en_ff)
        wait_ff <= slow ? 6'h3f : 6'h02;
      else if (wait_ff != 6'h00)
        wait_ff <= wait_ff - 6'h01;
    end
  end
  assign program_flash_ready_pin = (wait_ff == 6'h00);
  assign osc_ready_pin = (wait_ff < 6'h02);
endmodule // spc_core_model

/* File: tb/testbench.sv */
// Self-checking bench for the sleep/idle power controller
`timescale 1ns/100ps
module testbench;
  reg pclk, presetn, psel, penable, pwrite, sleep_exec, irq_wake_group0, irq_wake_periph, irq_clock_switch;
  reg peripheral_irq_enable, global_irq_enable, isr_entry, reset_source_pin, wdt_timeout_pin, brownout_enable;
  reg crystal_mode, low_freq_osc_req, high_freq_osc_req, second_osc_req, adc_on_bit, adc_on_rc_clock;
  reg clock_out_enable_n, slow, vec_seen, abort_seen, wd_seen, err_bit;
  reg [7:0] port_periph_active;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd, r;
  wire [31:0] prdata;
  wire [15:0] vector_addr_ff;
  wire [7:0] port_hold_ff;
  wire pready, pslverr, cpu_clk_en_ff, sys_clk_en_ff, periph_clk_en_ff, clk_out_en_ff, low_freq_internal_osc_en_ff;
  wire high_freq_internal_osc_en_ff, secondary_osc_en_ff, adc_abort_ff, adc_power_en_ff, regulator_low_power_ff;
  wire watchdog_clear_ff, device_reset_ff, exec_prefetch_ff, vector_req_ff, cpu_run_ff, power_down_flag_ff;
  wire timeout_flag_ff, osc_clk_pin, program_flash_ready_pin, osc_ready_pin;
  integer err_total, compares, i, n;
  spc_power_ctrl #(.OST_PERIODS(4), .VREG_CYCLES(2)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sleep_exec, .irq_wake_group0, .irq_wake_periph, .irq_clock_switch,
    .peripheral_irq_enable, .global_irq_enable, .isr_entry, .reset_source_pin, .wdt_enabled_in_sleep(1'b1),
    .wdt_timeout_pin, .program_flash_ready_pin, .osc_ready_pin, .brownout_ready_pin(1'b1), .brownout_enable,
    .crystal_mode, .osc_clk_pin, .low_freq_osc_req, .high_freq_osc_req, .second_osc_req, .adc_on_bit,
    .adc_on_rc_clock, .clock_out_enable_n, .port_periph_active, .cpu_clk_en_ff, .sys_clk_en_ff, .periph_clk_en_ff,
    .clk_out_en_ff, .low_freq_internal_osc_en_ff, .high_freq_internal_osc_en_ff, .secondary_osc_en_ff,
    .adc_abort_ff, .adc_power_en_ff, .port_hold_ff, .regulator_low_power_ff, .watchdog_clear_ff, .device_reset_ff,
    .exec_prefetch_ff, .vector_req_ff, .vector_addr_ff, .cpu_run_ff, .power_down_flag_ff, .timeout_flag_ff);
  spc_core_model u_core (.pclk, .presetn, .slow, .cpu_clk_en_ff, .osc_clk_pin, .program_flash_ready_pin,
    .osc_ready_pin);
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  function [31:0] ctl_after(input [2:0] c);
    ctl_after = {24'h0, c[2], c[1] & ~c[0], c[0], 5'h00};
  endfunction
  task check(input [127:0] what, input [31:0] exp, input [31:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("ERROR %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task apb(input wr, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
        @(posedge pclk);
      end
      rd = prdata;
      err_bit = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge so a following call never drives psel twice in one step
      @(posedge pclk);
    end
  endtask
  task do_sleep;
    begin
      sleep_exec <= 1'b1;
      @(posedge pclk);
      sleep_exec <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask
  task wait_run;
    begin
      n = 0;
      while (exec_prefetch_ff !== 1'b1 && n < 400) begin
        n = n + 1;
        @(posedge pclk);
      end
      check("woke", 1, n < 400);
    end
  endtask
  task do_reset;
    begin
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
    end
  endtask
  task give_verdict;
    begin
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // ------------------------------------------------------------
  // Clock, pulse capture, watchdog
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (adc_abort_ff === 1'b1)
      abort_seen <= 1'b1;
    if (vector_req_ff === 1'b1)
      vec_seen <= 1'b1;
    if (watchdog_clear_ff === 1'b1)
      wd_seen <= 1'b1;
  end
  initial begin
    #800000;
    err_total = err_total + 1;
    give_verdict;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, sleep_exec, irq_wake_group0, irq_wake_periph, irq_clock_switch} = 8'h00;
    {global_irq_enable, isr_entry, reset_source_pin, wdt_timeout_pin, brownout_enable, crystal_mode} = 6'h00;
    {low_freq_osc_req, high_freq_osc_req, second_osc_req, adc_on_bit, adc_on_rc_clock, slow} = 6'h00;
    {peripheral_irq_enable, clock_out_enable_n, vec_seen, abort_seen, wd_seen} = 5'h18;
    {port_periph_active, paddr, pwdata, err_total, compares} = 0;
    r = $urandom(32'h8b45);
    do_reset;
    for (i = 0; i < 3; i = i + 1) begin
      apb(1'b0, i * 4, 0);
      check("reset value", (i == 1), rd);
    end
    check("reset flags", 3, {power_down_flag_ff, timeout_flag_ff});
    apb(1'b1, 12'h020, 32'h5);
    check("unmapped error", 1, err_bit);
    $display("reset test done");
    for (i = 0; i < 8; i = i + 1) begin
      r = $urandom;
      {adc_on_bit, adc_on_rc_clock, low_freq_osc_req, high_freq_osc_req, second_osc_req} <= r[4:0];
      {crystal_mode, slow, global_irq_enable, clock_out_enable_n, brownout_enable} <= r[9:5];
      port_periph_active <= r[17:10];
      apb(1'b1, 12'h008, {29'h0, r[20:18]});
      apb(1'b1, 12'h004, {30'h0, r[21], 1'b1});
      apb(1'b1, 12'h000, {24'h0, r[24:22], 5'h00});
      abort_seen <= 1'b0;
      do_sleep;
      check("cpu clock", 0, cpu_clk_en_ff);
      check("flags", 1, {power_down_flag_ff, timeout_flag_ff});
      check("sys clock", r[24], sys_clk_en_ff);
      check("periph clock", r[24], periph_clk_en_ff);
      check("clock out", r[24] & ~r[6], clk_out_en_ff);
      check("adc power", r[4] & (r[24] | r[3]), adc_power_en_ff);
      check("adc abort", r[4] & ~r[24] & ~r[3], abort_seen);
      if (!r[24]) begin
        check("osc enables", {r[2] | r[19], r[1] | r[18], r[0] | r[20]},
          {low_freq_internal_osc_en_ff, high_freq_internal_osc_en_ff, secondary_osc_en_ff});
        check("port hold", {~r[17:10]}, port_hold_ff);
        check("regulator", r[21], regulator_low_power_ff);
      end
      vec_seen <= 1'b0;
      wd_seen <= 1'b0;
      irq_wake_group0 <= 1'b1;
      wait_run;
      irq_wake_group0 <= 1'b0;
      repeat (4) @(posedge pclk);
      check("vector", r[7], vec_seen);
      check("wdt cleared", 1, wd_seen);
      isr_entry <= 1'b1;
      @(posedge pclk);
      isr_entry <= 1'b0;
      apb(1'b0, 12'h000, 0);
      check("cpu ctrl", ctl_after(r[24:22]), rd);
      $display("random pass %0d done", i);
    end
    apb(1'b1, 12'h010, 32'h2);
    irq_wake_group0 <= 1'b1;
    do_sleep;
    check("noop cpu clock", 1, cpu_clk_en_ff);
    apb(1'b0, 12'h00c, 0);
    check("noop flags", 3, rd[1:0]);
    irq_wake_group0 <= 1'b0;
    apb(1'b1, 12'h000, 0);
    do_sleep;
    {irq_wake_group0, irq_clock_switch, irq_wake_periph, peripheral_irq_enable} <= 4'h2;
    repeat (20) @(posedge pclk);
    check("peripheral_irq_enable gated wake", 0, cpu_clk_en_ff);
    {irq_clock_switch, peripheral_irq_enable} <= 2'h3;
    repeat (20) @(posedge pclk);
    check("clock switch wake", 0, cpu_clk_en_ff);
    irq_clock_switch <= 1'b0;
    wait_run;
    {irq_wake_group0, irq_clock_switch, irq_wake_periph} <= 3'h0;
    $display("wake gating test done");
    apb(1'b1, 12'h000, 32'hc0);
    do_sleep;
    wdt_timeout_pin <= 1'b1;
    @(posedge pclk);
    wdt_timeout_pin <= 1'b0;
    n = 0;
    err_bit = 1'b0;
    while (cpu_clk_en_ff !== 1'b1 && n < 400) begin
      err_bit = err_bit | (device_reset_ff === 1'b1);
      n = n + 1;
      @(posedge pclk);
    end
    check("idle wdt wake", 1, n < 400);
    repeat (4) @(posedge pclk);
    check("idle wdt reset", 0, err_bit | device_reset_ff);
    apb(1'b0, 12'h000, 0);
    check("doze kept", 32'hc0, rd);
    apb(1'b1, 12'h000, 0);
    do_sleep;
    reset_source_pin <= 1'b1;
    n = 0;
    while (device_reset_ff !== 1'b1 && n < 20) begin
      n = n + 1;
      @(posedge pclk);
    end
    check("reset wake", 1, device_reset_ff);
    reset_source_pin <= 1'b0;
    do_reset;
    $display("idle and reset wake tests done");
    give_verdict;
  end
endmodule // testbench
